// ===== design/dps_pkg.sv
// Shared constants and types for the semaphore port controller
package dps_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DATA_W = 8;
  localparam int INDEX_W = 3;
  localparam logic [INDEX_W-1:0] LAST_INDEX = 3'h7;
  localparam logic [INDEX_W-1:0] FIRST_INDEX = 3'h0;
  localparam int SYNC_STAGES = 2;

  // Pin timing in ns
  localparam int T_WRITE_PULSE_NS = 30;
  localparam int T_READ_ACCESS_NS = 40;
  localparam int T_SELECT_GAP_NS = 20;

  // Least times round up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'(ns_to_cycles(T_WRITE_PULSE_NS));
  localparam logic [CNT_W-1:0] READ_CYC = CNT_W'(ns_to_cycles(T_READ_ACCESS_NS) + SYNC_STAGES);
  localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(ns_to_cycles(T_SELECT_GAP_NS));
  localparam logic [CNT_W-1:0] CNT_LAST = 8'h01;

  typedef enum logic [1:0] {
    OP_CLAIM,
    OP_RELEASE,
    OP_READ,
    OP_INIT
  } dps_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_GAP
  } dps_state_e;
endpackage

// ===== design/dps_sync.sv
// Two-flop synchroniser for the semaphore data pins
`timescale 1ns/1ps
module dps_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1Reg <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end
endmodule

// ===== design/dps_sem_host.sv
// Controller driving one port of a dual-port RAM semaphore flag bank
`timescale 1ns/1ps
// Contract
// - Flags are active low: write zero to request, one to release.
// - Semaphore select low opens flag space; other strobes behave as SRAM.
// - Polling must deassert select or output enable between reads.
// - Claim by writing zero then reading back; own only on zero.
// - After a failed claim, keep reading or write one to withdraw.
// - At start, write one to all eight flags from each port.
// - Hold memory chip enable high during any semaphore access.
module dps_sem_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [1:0] cmdOp,
  input wire logic [dps_pkg::INDEX_W-1:0] cmdIndex,
  output logic respValid,
  output logic respGranted,
  output logic respFlag,
  output logic chipEnableN,
  output logic semaphore_select_n,
  output logic outputEnableN,
  output logic readWriteN,
  output logic [dps_pkg::INDEX_W-1:0] flag_index,
  output logic [dps_pkg::DATA_W-1:0] dataOut,
  output logic dataOutEnN,
  input wire logic [dps_pkg::DATA_W-1:0] dataIn
);
  dps_pkg::dps_state_e stateReg, stateNext;
  dps_pkg::dps_op_e opReg;
  logic [dps_pkg::CNT_W-1:0] cntReg;
  logic [dps_pkg::INDEX_W-1:0] idxReg;
  logic wrBitReg;
  logic nextReadReg;
  logic doneReg;
  logic withdrawReg;
  logic flagReg;
  logic [dps_pkg::DATA_W-1:0] dataSync;
  logic accessEnd;
  logic gapEnd;
  logic flagNow;

  dps_sync #(.WIDTH(dps_pkg::DATA_W)) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(dataIn),
    .syncOut(dataSync)
  );

  // Flag reads as one only when every replicated bit agrees
  assign flagNow = &dataSync;
  assign cmdReady = (stateReg == dps_pkg::ST_IDLE);
  assign accessEnd = (stateReg == dps_pkg::ST_WRITE || stateReg == dps_pkg::ST_READ) && cntReg == dps_pkg::CNT_LAST;
  assign gapEnd = (stateReg == dps_pkg::ST_GAP) && cntReg == dps_pkg::CNT_LAST;

  // Sequencer: each access is followed by a deselect gap
  always_comb
  begin
    stateNext = stateReg;
    unique case (stateReg)
      dps_pkg::ST_IDLE:
        if (cmdValid)
          stateNext = (cmdOp == dps_pkg::OP_READ) ? dps_pkg::ST_READ : dps_pkg::ST_WRITE;
      dps_pkg::ST_WRITE, dps_pkg::ST_READ:
        if (accessEnd)
          stateNext = dps_pkg::ST_GAP;
      dps_pkg::ST_GAP:
        if (gapEnd)
          stateNext = doneReg ? dps_pkg::ST_IDLE : (nextReadReg ? dps_pkg::ST_READ : dps_pkg::ST_WRITE);
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stateReg <= dps_pkg::ST_IDLE;
    else
      stateReg <= stateNext;
  end

  // Phase timer reloads on every state change
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cntReg <= dps_pkg::CNT_LAST;
    else if (stateNext != stateReg)
      unique case (stateNext)
        dps_pkg::ST_WRITE: cntReg <= dps_pkg::WRITE_CYC;
        dps_pkg::ST_READ: cntReg <= dps_pkg::READ_CYC;
        dps_pkg::ST_GAP: cntReg <= dps_pkg::GAP_CYC;
        dps_pkg::ST_IDLE: cntReg <= dps_pkg::CNT_LAST;
      endcase
    else if (cntReg != dps_pkg::CNT_LAST)
      cntReg <= cntReg - dps_pkg::CNT_LAST;
  end

  // Command capture and follow-on decision at each access end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      opReg <= dps_pkg::OP_READ;
      idxReg <= dps_pkg::FIRST_INDEX;
      wrBitReg <= 1'b1;
      nextReadReg <= 1'b0;
      doneReg <= 1'b0;
      withdrawReg <= 1'b0;
      flagReg <= 1'b1;
    end
    else if (stateReg == dps_pkg::ST_IDLE && cmdValid)
    begin
      opReg <= dps_pkg::dps_op_e'(cmdOp);
      idxReg <= (cmdOp == dps_pkg::OP_INIT) ? dps_pkg::FIRST_INDEX : cmdIndex;
      wrBitReg <= (cmdOp != dps_pkg::OP_CLAIM);
      nextReadReg <= 1'b0;
      doneReg <= 1'b0;
      withdrawReg <= 1'b0;
    end
    else if (accessEnd && stateReg == dps_pkg::ST_WRITE)
    begin
      if (opReg == dps_pkg::OP_CLAIM && !withdrawReg)
        nextReadReg <= 1'b1;
      else if (opReg == dps_pkg::OP_INIT && idxReg != dps_pkg::LAST_INDEX)
        nextReadReg <= 1'b0;
      else
        doneReg <= 1'b1;
    end
    else if (accessEnd && stateReg == dps_pkg::ST_READ)
    begin
      flagReg <= flagNow;
      if (opReg == dps_pkg::OP_CLAIM && flagNow)
      begin
        // Failed claim withdraws, or it could be handed a stale token later
        withdrawReg <= 1'b1;
        wrBitReg <= 1'b1;
        nextReadReg <= 1'b0;
      end
      else
        doneReg <= 1'b1;
    end
    else if (gapEnd && opReg == dps_pkg::OP_INIT && !doneReg)
      idxReg <= idxReg + 3'h1;
  end

  // Pins registered from the next state so strobes never glitch
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      semaphore_select_n <= 1'b1;
      outputEnableN <= 1'b1;
      readWriteN <= 1'b1;
      dataOutEnN <= 1'b1;
    end
    else
    begin
      semaphore_select_n <= !(stateNext == dps_pkg::ST_WRITE || stateNext == dps_pkg::ST_READ);
      outputEnableN <= (stateNext != dps_pkg::ST_READ);
      readWriteN <= (stateNext != dps_pkg::ST_WRITE);
      dataOutEnN <= (stateNext != dps_pkg::ST_WRITE);
    end
  end

  // Memory array is never selected by this controller
  always_ff @(posedge clk)
  begin
    chipEnableN <= 1'b1;
  end

  assign flag_index = idxReg;
  assign dataOut = {dps_pkg::DATA_W{wrBitReg}};

  // Completion pulse with the claim outcome
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      respValid <= 1'b0;
      respGranted <= 1'b0;
    end
    else
    begin
      respValid <= gapEnd && doneReg;
      respGranted <= gapEnd && doneReg && opReg == dps_pkg::OP_CLAIM && !withdrawReg && !flagReg;
    end
  end
  assign respFlag = flagReg;

  sequence s_failedRead;
    stateReg == dps_pkg::ST_READ && accessEnd && opReg == dps_pkg::OP_CLAIM && flagNow;
  endsequence

  sequence s_withdrawWrite;
    !readWriteN && !semaphore_select_n && dataOut[0];
  endsequence

  a_ce_stays_high: assert property (@(posedge clk) disable iff (sys_rst)
    !semaphore_select_n |-> chipEnableN)
    else $error("Chip enable low during semaphore access");

  a_write_in_sem: assert property (@(posedge clk) disable iff (sys_rst)
    !readWriteN |-> !semaphore_select_n && outputEnableN && !dataOutEnN)
    else $error("Write strobe outside semaphore select");

  a_poll_deselect: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(semaphore_select_n) |=> semaphore_select_n)
    else $error("Select gap too short between accesses");

  a_claim_writes_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !readWriteN && opReg == dps_pkg::OP_CLAIM && !withdrawReg |-> dataOut == '0)
    else $error("Claim did not write zero");

  a_claim_read_back: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(readWriteN) && opReg == dps_pkg::OP_CLAIM && !withdrawReg |-> ##[1:6] !outputEnableN)
    else $error("Claim write not followed by read back");

  a_grant_on_zero: assert property (@(posedge clk) disable iff (sys_rst)
    respGranted |-> respValid && !flagReg)
    else $error("Grant without zero read back");

  a_fail_withdraws: assert property (@(posedge clk) disable iff (sys_rst)
    s_failedRead |-> ##[1:6] s_withdrawWrite)
    else $error("Failed claim not withdrawn");

  a_init_all_flags: assert property (@(posedge clk) disable iff (sys_rst)
    respValid && opReg == dps_pkg::OP_INIT |-> idxReg == dps_pkg::LAST_INDEX && wrBitReg)
    else $error("Init ended before last flag");
endmodule

// ===== testbench/dps_sem_dev.sv
// Behavioural two-port semaphore flag bank facing the host controller
`timescale 1ns/1ps
module dps_sem_dev (
  input wire logic lSelN,
  input wire logic lOeN,
  input wire logic lRwN,
  input wire logic [2:0] lIdx,
  input wire logic [7:0] lDin,
  output logic [7:0] lDout
);
  // Eight request latches per side, never cleared at power-up
  // Host side wakes with stale requests, so a flag that init skips ends up owned
  logic [7:0] reqL = 8'h00;
  logic [7:0] reqR = 8'hXX;
  logic [7:0] ownL = 8'h00;
  logic [7:0] ownR = 8'h00;
  logic [7:0] rdVal = 8'hFF;
  logic [2:0] wIdx = 3'h0;
  logic wBit = 1'b1;
  logic wOn = 1'b0;
  logic rdOn = 1'b0;

  // Free flag goes to a pending zero; left wins an exact tie
  task automatic settle(input int i);
    if (!ownL[i] && !ownR[i])
    begin
      if (reqL[i] === 1'b0)
        ownL[i] = 1'b1;
      else if (reqR[i] === 1'b0)
        ownR[i] = 1'b1;
    end
  endtask

  // Zero requests, one releases; a non-owner zero only waits
  task automatic put(input bit left, input int i, input logic b);
    reqL[i] = left ? b : reqL[i];
    reqR[i] = left ? reqR[i] : b;
    ownL[i] = ownL[i] & ~(left & b);
    ownR[i] = ownR[i] & ~(!left & b);
    settle(i);
  endtask

  // Second processor's port, worked by the bench
  task automatic rWrite(input int i, input logic b);
    put(1'b0, i, b);
  endtask

  function automatic logic rFlag(input int i);
    return ~ownR[i];
  endfunction

  // Write commits when the strobe pair closes; only bit 0 counts
  always @(lSelN, lRwN)
  begin
    if (!lSelN && !lRwN)
    begin
      wIdx = lIdx;
      wBit = lDin[0];
      wOn = 1'b1;
    end
    else if (wOn)
    begin
      wOn = 1'b0;
      put(1'b1, int'(wIdx), wBit);
    end
  end

  // Value frozen for the whole read, spread on all bits
  always @(lSelN, lOeN)
  begin
    if (!lSelN && !lOeN && !rdOn)
      rdVal = {8{~ownL[lIdx]}};
    rdOn = !lSelN && !lOeN;
  end

  // Released bus shows the inverse, so a stale sample cannot pass
  assign lDout = rdOn ? rdVal : ~rdVal;
endmodule

// ===== testbench/dual_port_semaphore_flags_tb_top.sv
// Self-checking bench for the semaphore port controller
`timescale 1ns/1ps
module dual_port_semaphore_flags_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdValid = 1'b0;
  logic [1:0] cmdOp = 2'h0;
  logic [2:0] cmdIndex = 3'h0;
  logic cmdReady, respValid, respGranted, respFlag, chipEnableN, semaphore_select_n;
  logic outputEnableN, readWriteN, dataOutEnN, gotGrant, gotFlag;
  logic [2:0] flag_index;
  logic [7:0] dataOut, dataIn;
  int nFail = 0;
  int checks = 0;

  always #5 clk = ~clk;

  dps_sem_host dps_sem_host_inst (.clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdIndex(cmdIndex), .respValid(respValid), .respGranted(respGranted), .respFlag(respFlag),
    .chipEnableN(chipEnableN), .semaphore_select_n(semaphore_select_n), .outputEnableN(outputEnableN),
    .readWriteN(readWriteN), .flag_index(flag_index), .dataOut(dataOut), .dataOutEnN(dataOutEnN), .dataIn(dataIn));

  dps_sem_dev dps_sem_dev_inst (.lSelN(semaphore_select_n), .lOeN(outputEnableN), .lRwN(readWriteN),
    .lIdx(flag_index), .lDin(dataOut), .lDout(dataIn));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command, then a bounded wait for its answer pulse
  task automatic run(input logic [1:0] op, input logic [2:0] idx);
    int n;
    @(negedge clk);
    chk(cmdReady, 1'b1);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdIndex = idx;
    @(negedge clk);
    cmdValid = 1'b0;
    chk(cmdReady, 1'b0);
    n = 0;
    while (respValid !== 1'b1 && n < 80)
    begin
      @(negedge clk);
      n++;
    end
    chk(respValid, 1'b1);
    gotGrant = respGranted;
    gotFlag = respFlag;
  endtask

  // Pins watched mid-cycle, where they have settled, while the flag space is open
  always @(negedge clk)
    if (!sys_rst && semaphore_select_n === 1'b0)
    begin
      chk(chipEnableN, 1'b1);
      chk(outputEnableN | readWriteN, 1'b1);
      chk(dataOutEnN, readWriteN);
    end

  task automatic scen_init();
    run(2'h3, 3'h0);
    for (int i = 0; i < 8; i++)
    begin
      dps_sem_dev_inst.rWrite(i, 1'b1);
      run(2'h2, 3'(i));
      chk(gotFlag, 1'b1);
    end
  endtask

  task automatic scen_handover();
    run(2'h0, 3'h7);
    chk({gotGrant, gotFlag}, 2'h2);
    chk(dps_sem_dev_inst.rFlag(7), 1'b1);
    dps_sem_dev_inst.rWrite(7, 1'b0);
    chk(dps_sem_dev_inst.rFlag(7), 1'b1);
    run(2'h1, 3'h7);
    chk(gotGrant, 1'b0);
    chk(dps_sem_dev_inst.rFlag(7), 1'b0);
    run(2'h2, 3'h7);
    chk(gotFlag, 1'b1);
  endtask

  task automatic scen_withdraw();
    run(2'h0, 3'h7);
    chk({gotGrant, gotFlag}, 2'h1);
    dps_sem_dev_inst.rWrite(7, 1'b1);
    run(2'h2, 3'h7);
    chk(gotFlag, 1'b1);
    run(2'h0, 3'h0);
    chk({gotGrant, gotFlag}, 2'h2);
    run(2'h1, 3'h0);
    chk(dps_sem_dev_inst.rFlag(0), 1'b1);
    dps_sem_dev_inst.rWrite(0, 1'b0);
    chk(dps_sem_dev_inst.rFlag(0), 1'b0);
  endtask

  task automatic end_of_test();
    $display("checks=%0d fails=%0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run needs about two hundred cycles; fifty times that means a hang
  initial
  begin
    #100000;
    nFail++;
    end_of_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk({cmdReady, respValid, semaphore_select_n}, 3'h5);
    chk(dataOut, 8'hFF);
    chk(flag_index, 3'h0);
    scen_init();
    scen_handover();
    scen_withdraw();
    end_of_test();
  end
endmodule
